// ==== rtl/tccm_top.v ====
// How it works
// - direction field 00 makes a compare output, anything else capture.
// - capture source: 01 input one, 10 input two, 11 internal trigger.
// - other mode bits are decoded according to the current direction.
// - fast enable lets a trigger event act on the reference at once.
// - preload off: a compare value write takes effect immediately.
// - preload on: a compare value write waits for the update event.
// - protection level 3 in compare locks preload bit and mode field.
// - mode 000 freezes the reference against matches.
// - mode 001 drives the reference high on a match.
// - mode 010 drives the reference low on a match.
// - mode 011 toggles the reference on each match.
// - mode 100 forces the reference low.
// - PWM mode 1: high while counter below compare value, else low.
// - PWM mode 2: high while counter above compare value, else low.
// - PWM level follows the compare result every cycle, so any mode switch or a lifted clear shows at once.
// - clear enable forces the reference low while external trigger high.
// - capture prescale takes every 1, 2, 4 or 8 input events.
`include "tccm_regs.vh"

module tccm_top
(
   // clock and reset
   input  wire        sys_clk,
   input  wire        rst_n,
   // ahb-lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output reg  [31:0] hrdata,
   // timer core side
   input  wire [15:0] counter,
   input  wire        update_evt,
   input  wire        trigger_evt,
   input  wire        internal_trigger_active,
   input  wire        filtered_external_trigger,
   input  wire        timer_input_one,
   input  wire        timer_input_two,
   input  wire        internal_trigger_source,
   // channel outputs
   output reg         channel_reference_output,
   output reg         capture_pulse
);

   // bus registers
   reg         ph_wr_r;
   reg         ph_rd_r;
   reg  [7:0]  ph_addr_r;
   reg         rd_wait_r;
   reg  [31:0] rd_mux;

   // software registers
   reg  [7:0]  mode_r;
   reg  [7:0]  mode_nxt;
   reg  [15:0] cmp_buf_r;
   reg  [15:0] cmp_act_r;
   reg  [15:0] cmp_act_nxt;
   reg         chan_en_r;
   reg  [1:0]  prot_r;
   reg         cap_flag_r;
   reg  [15:0] cap_val_r;

   // compare state
   reg         ref_nxt;

   // capture state
   reg         src_prev_r;
   reg         src_lvl;
   reg  [1:0]  psc_prev_r;
   wire        src_edge;
   wire        psc_clr;
   wire        psc_cap;

   wire        addr_ok;
   wire        wr_en;
   wire [1:0]  dir;
   wire        out_dir;
   wire        fast_en;
   wire        pre_en;
   wire [2:0]  ocm;
   wire        clr_en;
   wire [1:0]  psc;
   wire        match;
   wire        fast_trig;
   wire        cmp_lt;
   wire        cmp_gt;
   wire        pwm_lvl;
   wire        wr_cmp;
   wire        wr_stat;

   // ---------------------------------------------------------------
   // ahb-lite: writes finish with no wait, reads add one wait state
   // so that a read right behind a write sees the new value
   // ---------------------------------------------------------------
   assign addr_ok   = hsel && hready && htrans[1] == `TCCM_HTRANS_NSEQ;
   assign hreadyout = !rd_wait_r;
   assign hresp     = 1'b0;
   assign wr_en     = ph_wr_r;

   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         ph_wr_r   <= 1'b0;
         ph_rd_r   <= 1'b0;
         ph_addr_r <= 8'h00;
         rd_wait_r <= 1'b0;
         hrdata    <= 32'h00000000;
      end
      else
      begin
         if (hready)
         begin
            ph_wr_r   <= addr_ok && hwrite;
            ph_rd_r   <= addr_ok && !hwrite;
            rd_wait_r <= addr_ok && !hwrite;
            ph_addr_r <= haddr[7:0];
         end
         else
            rd_wait_r <= 1'b0;
         if (rd_wait_r)
            hrdata <= rd_mux;
      end
   end

   // unmapped offsets read zero and ignore writes
   always @*
   begin
      rd_mux = 32'h00000000;
      case (ph_addr_r)
         `TCCM_OFS_MODE:
            rd_mux[7:0] = mode_r;
         `TCCM_OFS_CMP:
            rd_mux[15:0] = cmp_buf_r;
         `TCCM_OFS_CTRL:
            rd_mux[2:0] = {prot_r, chan_en_r};
         `TCCM_OFS_STAT:
            rd_mux[3:0] = {dir, cap_flag_r, channel_reference_output};
         `TCCM_OFS_CAPV:
            rd_mux[15:0] = cap_val_r;
         `TCCM_OFS_ACT:
            rd_mux[15:0] = cmp_act_r;
         default:
            rd_mux = 32'h00000000;
      endcase
   end

   // ---------------------------------------------------------------
   // mode control register
   // ---------------------------------------------------------------
   assign dir     = mode_r[`TCCM_DIR_MSB:`TCCM_DIR_LSB];
   assign out_dir = (dir == `TCCM_DIR_OUT);
   // the same bits mean different things per direction
   assign fast_en = out_dir && mode_r[`TCCM_FAST_BIT];
   assign pre_en  = out_dir && mode_r[`TCCM_PRE_BIT];
   assign ocm     = mode_r[`TCCM_OCM_MSB:`TCCM_OCM_LSB];
   assign clr_en  = out_dir && mode_r[`TCCM_CLR_BIT];
   assign psc     = mode_r[`TCCM_PSC_MSB:`TCCM_PSC_LSB];

   always @*
   begin
      mode_nxt = mode_r;
      if (wr_en && ph_addr_r == `TCCM_OFS_MODE)
      begin
         mode_nxt = hwdata[7:0];
         if (chan_en_r)
            mode_nxt[`TCCM_DIR_MSB:`TCCM_DIR_LSB] = dir;
         if (prot_r == `TCCM_PROT_LOCK && out_dir)
         begin
            mode_nxt[`TCCM_PRE_BIT] = mode_r[`TCCM_PRE_BIT];
            mode_nxt[`TCCM_OCM_MSB:`TCCM_OCM_LSB] = ocm;
         end
      end
   end

   // ---------------------------------------------------------------
   // compare value: buffer and active copy
   // ---------------------------------------------------------------
   assign wr_cmp  = wr_en && ph_addr_r == `TCCM_OFS_CMP;
   assign wr_stat = wr_en && ph_addr_r == `TCCM_OFS_STAT;

   // pwm without preload relies on software using single pulse mode
   always @*
   begin
      cmp_act_nxt = cmp_act_r;
      if (wr_cmp && !pre_en)
         cmp_act_nxt = hwdata[15:0];
      else if (pre_en && update_evt)
         cmp_act_nxt = wr_cmp ? hwdata[15:0] : cmp_buf_r;
   end

   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         mode_r    <= `TCCM_MODE_RST;
         cmp_buf_r <= `TCCM_CMP_RST;
         cmp_act_r <= `TCCM_CMP_RST;
         chan_en_r <= 1'b0;
         prot_r    <= 2'h0;
      end
      else
      begin
         mode_r    <= mode_nxt;
         cmp_act_r <= cmp_act_nxt;
         if (wr_cmp)
            cmp_buf_r <= hwdata[15:0];
         if (wr_en && ph_addr_r == `TCCM_OFS_CTRL)
         begin
            chan_en_r <= hwdata[`TCCM_EN_BIT];
            prot_r    <= hwdata[`TCCM_PROT_MSB:`TCCM_PROT_LSB];
         end
      end
   end

   // ---------------------------------------------------------------
   // reference output
   // ---------------------------------------------------------------
   assign match     = (counter == cmp_act_r);
   assign fast_trig = fast_en && trigger_evt;
   assign cmp_lt    = (counter < cmp_act_r);
   assign cmp_gt    = (counter > cmp_act_r);
   // the level is worked out afresh each cycle, so a lifted clear or a
   // mode switch lands at once instead of waiting for the next crossing
   assign pwm_lvl   = (ocm == `TCCM_OCM_PWM1) ? cmp_lt : cmp_gt;

   always @*
   begin
      ref_nxt = channel_reference_output;
      if (!out_dir)
         ref_nxt = 1'b0;
      else
      begin
         case (ocm)
            `TCCM_OCM_FRZ:
               ref_nxt = channel_reference_output;
            `TCCM_OCM_HIGH:
               if (match || fast_trig)
                  ref_nxt = 1'b1;
            `TCCM_OCM_LOW:
               if (match || fast_trig)
                  ref_nxt = 1'b0;
            `TCCM_OCM_TOG:
               if (match || fast_trig)
                  ref_nxt = !channel_reference_output;
            `TCCM_OCM_FLOW:
               ref_nxt = 1'b0;
            `TCCM_OCM_PWM1:
            begin
               ref_nxt = pwm_lvl;
               if (fast_trig)
                  ref_nxt = 1'b1;
            end
            `TCCM_OCM_PWM2:
            begin
               ref_nxt = pwm_lvl;
               if (fast_trig)
                  ref_nxt = 1'b0;
            end
            `TCCM_OCM_RSVD:
               ref_nxt = channel_reference_output;
            default:
               ref_nxt = channel_reference_output;
         endcase
         // clear has the last word over every mode
         if (clr_en && filtered_external_trigger)
            ref_nxt = 1'b0;
      end
   end

   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         channel_reference_output <= 1'b0;
      end
      else
      begin
         channel_reference_output <= ref_nxt;
      end
   end

   // ---------------------------------------------------------------
   // capture path
   // ---------------------------------------------------------------
   always @*
   begin
      case (dir)
         `TCCM_DIR_TI1:
            src_lvl = timer_input_one;
         `TCCM_DIR_TI2:
            src_lvl = timer_input_two;
         `TCCM_DIR_TRC:
            src_lvl = internal_trigger_source
                      && internal_trigger_active;
         default:
            src_lvl = 1'b0;
      endcase
   end

   assign src_edge = src_lvl && !src_prev_r;
   // restart the count when the prescale changes or capture stops
   assign psc_clr  = !chan_en_r || out_dir || (psc != psc_prev_r);

   tccm_psc u_psc
   (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .clr     (psc_clr),
      .psc     (psc),
      .evt     (src_edge),
      .cap     (psc_cap)
   );

   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         src_prev_r    <= 1'b0;
         psc_prev_r    <= 2'h0;
         cap_flag_r    <= 1'b0;
         cap_val_r     <= 16'h0000;
         capture_pulse <= 1'b0;
      end
      else
      begin
         src_prev_r    <= src_lvl;
         psc_prev_r    <= psc;
         capture_pulse <= psc_cap;
         if (psc_cap)
            cap_val_r <= counter;
         // a new capture beats a clear in the same cycle
         if (psc_cap)
            cap_flag_r <= 1'b1;
         else if (wr_stat && hwdata[`TCCM_ST_CAPF_BIT])
            cap_flag_r <= 1'b0;
      end
   end

endmodule

// ==== rtl/tccm_regs.vh ====
`ifndef TCCM_REGS_VH
`define TCCM_REGS_VH

// register byte offsets
`define TCCM_OFS_MODE      8'h20
`define TCCM_OFS_CMP       8'h24
`define TCCM_OFS_CTRL      8'h28
`define TCCM_OFS_STAT      8'h2c
`define TCCM_OFS_CAPV      8'h30
`define TCCM_OFS_ACT       8'h34

// reset values
`define TCCM_MODE_RST      8'h00
`define TCCM_CMP_RST       16'h0000
`define TCCM_CTRL_RST      3'h0

// mode control fields, both directions
`define TCCM_DIR_LSB       0
`define TCCM_DIR_MSB       1
`define TCCM_FAST_BIT      2
`define TCCM_PRE_BIT       3
`define TCCM_OCM_LSB       4
`define TCCM_OCM_MSB       6
`define TCCM_CLR_BIT       7
`define TCCM_PSC_LSB       2
`define TCCM_PSC_MSB       3
`define TCCM_FILT_LSB      4
`define TCCM_FILT_MSB      7

// control and status fields
`define TCCM_EN_BIT        0
`define TCCM_PROT_LSB      1
`define TCCM_PROT_MSB      2
`define TCCM_ST_REF_BIT    0
`define TCCM_ST_CAPF_BIT   1
`define TCCM_ST_DIR_LSB    2
`define TCCM_ST_DIR_MSB    3

// direction codes
`define TCCM_DIR_OUT       2'h0
`define TCCM_DIR_TI1       2'h1
`define TCCM_DIR_TI2       2'h2
`define TCCM_DIR_TRC       2'h3

// compare mode codes
`define TCCM_OCM_FRZ       3'h0
`define TCCM_OCM_HIGH      3'h1
`define TCCM_OCM_LOW       3'h2
`define TCCM_OCM_TOG       3'h3
`define TCCM_OCM_FLOW      3'h4
`define TCCM_OCM_PWM1      3'h5
`define TCCM_OCM_RSVD      3'h6
`define TCCM_OCM_PWM2      3'h7

`define TCCM_PROT_LOCK     2'h3
`define TCCM_HTRANS_NSEQ   1'b1
`define TCCM_CNT_W         16

`endif

// ==== rtl/tccm_psc.v ====
module tccm_psc
(
   // clock and reset
   input  wire       sys_clk,
   input  wire       rst_n,
   // control
   input  wire       clr,
   input  wire [1:0] psc,
   // events
   input  wire       evt,
   output reg        cap
);

   reg  [2:0] cnt_r;
   reg  [2:0] cnt_nxt;
   wire [2:0] last;

   // 1, 2, 4 or 8 events per capture
   assign last = (3'h1 << psc) - 3'h1;

   always @*
   begin
      cnt_nxt = cnt_r;
      if (clr)
         cnt_nxt = 3'h0;
      else if (evt)
         cnt_nxt = (cnt_r == last) ? 3'h0 : cnt_r + 3'h1;
   end

   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         cnt_r <= 3'h0;
         cap   <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         cap   <= !clr && evt && (cnt_r == last);
      end
   end

endmodule

// ==== bench/tccm_core_model.sv ====
// stands in for the timer counter and update logic beside the channel
module tccm_core_model
(
   // clock
   input  wire        sys_clk,
   // control from the bench
   input  wire        ld,
   input  wire [15:0] ld_val,
   input  wire        run,
   input  wire        upd,
   // timer core outputs
   output logic [15:0] counter,
   output logic        update_evt
);
   timeunit 1ns;
   timeprecision 1ps;
   initial counter = 16'h0000;
   initial update_evt = 1'b0;
   // update event is a single cycle pulse, as the channel expects
   always @(posedge sys_clk)
   begin
      update_evt <= upd;
      if (ld)
         counter <= ld_val;
      else if (run)
         counter <= counter + 16'h0001;
   end
endmodule

// ==== bench/tccm_properties.sv ====
module tccm_properties
(
   // clock and reset
   input wire        sys_clk,
   input wire        rst_n,
   // bus
   input wire        hsel,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire        hready,
   input wire        hreadyout,
   input wire        hresp,
   input wire [31:0] hrdata,
   // channel
   input wire        channel_reference_output,
   input wire        capture_pulse
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   wire take = hsel && hready && htrans[1];
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("hresp not okay");
   a_rd_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   a_wr_nowait: assert property (take && hwrite |=> hreadyout)
      else $error("write stalled");
   a_idle_ready: assert property (!(take && !hwrite) |=> hreadyout)
      else $error("ready low without read");
   a_one_wait: assert property (!hreadyout |=> hreadyout)
      else $error("wait state too long");
   // read data must stand until the next read loads it
   a_rdata_hold: assert property (hreadyout |=> $stable(hrdata))
      else $error("read data moved");
   a_rst_vals: assert property (disable iff (1'b0) !rst_n |=>
      !channel_reference_output && !capture_pulse && hreadyout
      && hrdata == 32'h0000_0000)
      else $error("reset values wrong");
   a_cap_single: assert property (capture_pulse |=> !capture_pulse)
      else $error("capture pulse too long");
   c_read: cover property (take && !hwrite);
   c_cap: cover property (capture_pulse);
   c_ref: cover property ($rose(channel_reference_output));
endmodule
bind tccm_top tccm_properties i_tccm_properties (.sys_clk, .rst_n, .hsel,
   .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
   .channel_reference_output, .capture_pulse);

// ==== bench/tb_top.sv ====
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [7:0] m; logic [15:0] c, n; logic r;} tccm_row_t;
   logic        sys_clk = 0, rst_n = 0, hsel = 0, hwrite = 0, etr = 0;
   logic        ld = 0, run = 0, upd = 0, trg = 0, ita = 0;
   logic [31:0] haddr = 0, hwdata = 0, rd;
   logic [1:0]  htrans = 0;
   logic [2:0]  src = 0;
   logic [15:0] ld_val = 0;
   wire         hreadyout, hresp, ref_o, cap, upd_evt;
   wire  [31:0] hrdata;
   wire  [15:0] cnt;
   int          n_fail = 0, check_count = 0, cyc = 0, ncap = 0, n0;
   tccm_row_t   rows [11] = '{
      '{8'h10, 5, 5, 1},
      '{8'h00, 9, 9, 1},
      '{8'h20, 9, 9, 0},
      '{8'h10, 2, 2, 1},
      '{8'h60, 4, 4, 1},
      '{8'h40, 4, 3, 0},
      '{8'h00, 5, 3, 0},
      '{8'h50, 5, 3, 1},
      '{8'h50, 5, 7, 0},
      '{8'h70, 5, 7, 1},
      '{8'h70, 5, 3, 0}};
   always #4 sys_clk = ~sys_clk;
   tccm_top i_tccm_top (.sys_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
      .hrdata, .counter(cnt), .update_evt(upd_evt), .trigger_evt(trg),
      .internal_trigger_active(ita), .filtered_external_trigger(etr),
      .timer_input_one(src[0]), .timer_input_two(src[1]),
      .internal_trigger_source(src[2]), .channel_reference_output(ref_o),
      .capture_pulse(cap));
   tccm_core_model i_tccm_core_model (.sys_clk, .ld, .ld_val, .run, .upd,
      .counter(cnt), .update_evt(upd_evt));
   task finish_test;
      $display("checks %0d fails %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task wt(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // master holds each phase until it samples hready high
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      hsel <= 1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1) @(posedge sys_clk);
      htrans <= 2'h0;
      hsel <= 0;
      hwdata <= d;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1) @(posedge sys_clk);
      rd = hrdata;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         n_fail++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask
   task cnt_set(input logic [15:0] v);
      @(posedge sys_clk);
      ld <= 1;
      ld_val <= v;
      @(posedge sys_clk);
      ld <= 0;
   endtask
   // edges spaced by at least two cycles so the source sampler sees each one
   task pls(input int b);
      @(posedge sys_clk);
      src[b] <= 1;
      wt(2);
      src[b] <= 0;
      wt(2);
   endtask
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cap === 1'b1)
         ncap++;
      if (cyc == 20000)
      begin
         n_fail++;
         finish_test;
      end
   end
   initial
   begin
      wt(10);
      rst_n <= 1;
      bus(0, 8'h20, 0);
      chk("mode_rst", 0, rd);
      chk("ref_rst", 0, ref_o);
      $display("test reset done");
      foreach (rows[i])
      begin
         bus(1, 8'h20, rows[i].m);
         bus(1, 8'h24, rows[i].c);
         cnt_set(rows[i].n);
         wt(3);
         chk("ref", rows[i].r, ref_o);
         bus(0, 8'h34, 0);
         chk("active", rows[i].c, rd);
      end
      $display("test rows done");
      bus(1, 8'h20, 8'h58);
      bus(1, 8'h24, 32'h100);
      bus(0, 8'h34, 0);
      chk("preload_hold", 5, rd);
      @(posedge sys_clk) upd <= 1;
      @(posedge sys_clk) upd <= 0;
      wt(2);
      bus(0, 8'h34, 0);
      chk("preload_upd", 32'h100, rd);
      bus(1, 8'h28, 6);
      bus(1, 8'h20, 8'h10);
      bus(0, 8'h20, 0);
      chk("lock", 8'h58, rd);
      bus(1, 8'h28, 1);
      bus(1, 8'h20, 8'h01);
      bus(0, 8'h20, 0);
      chk("dir_lock", 0, rd);
      bus(1, 8'h28, 0);
      $display("test locks done");
      ita <= 1;
      for (int d = 1; d < 4; d++)
      begin
         bus(1, 8'h20, {d[1:0], d[1:0]});
         bus(1, 8'h28, 1);
         bus(0, 8'h2c, 0);
         chk("dir", d, rd[3:2]);
         n0 = ncap;
         for (int b = 0; b < 3; b++)
            if (b != d - 1)
               repeat (8) pls(b);
         wt(3);
         chk("cap_other", 0, ncap - n0);
         repeat (8) pls(d - 1);
         wt(3);
         chk("cap", 8 >> d, ncap - n0);
         chk("ref_cap", 0, ref_o);
         bus(1, 8'h28, 0);
      end
      ita <= 0;
      bus(1, 8'h20, 8'h03);
      bus(1, 8'h28, 1);
      n0 = ncap;
      repeat (2) pls(2);
      wt(3);
      chk("trc_idle", 0, ncap - n0);
      bus(1, 8'h28, 0);
      bus(1, 8'h20, 8'h01);
      cnt_set(16'h0123);
      bus(1, 8'h28, 1);
      bus(1, 8'h2c, 2);
      n0 = ncap;
      repeat (3) pls(0);
      wt(3);
      chk("cap_psc1", 3, ncap - n0);
      bus(0, 8'h30, 0);
      chk("cap_val", 16'h0123, rd);
      bus(0, 8'h2c, 0);
      chk("cap_flag", 1, rd[1]);
      bus(1, 8'h2c, 2);
      bus(0, 8'h2c, 0);
      chk("cap_clr", 0, rd[1]);
      bus(1, 8'h28, 0);
      $display("test capture done");
      bus(1, 8'h20, 8'hd0);
      bus(1, 8'h24, 5);
      cnt_set(3);
      etr <= 1;
      wt(3);
      chk("clear_on", 0, ref_o);
      etr <= 0;
      wt(3);
      chk("clear_off", 1, ref_o);
      bus(1, 8'h20, 8'h50);
      etr <= 1;
      wt(3);
      chk("clear_dis", 1, ref_o);
      etr <= 0;
      for (int f = 0; f < 2; f++)
      begin
         bus(1, 8'h20, 8'h40);
         bus(1, 8'h20, 8'h10 | (f << 2));
         @(posedge sys_clk) trg <= 1;
         @(posedge sys_clk) trg <= 0;
         wt(2);
         chk("fast", f, ref_o);
      end
      bus(1, 8'h20, 8'h40);
      bus(1, 8'h20, 8'h30);
      for (int t = 1; t < 3; t++)
      begin
         cnt_set(4);
         @(posedge sys_clk) run <= 1;
         wt(3);
         run <= 0;
         wt(2);
         chk("toggle", t & 1, ref_o);
      end
      bus(0, 8'h3c, 0);
      chk("unmapped", 0, rd);
      $display("test compare done");
      finish_test;
   end
endmodule
